/* File: clock_source_select.v */
`include "clock_source_select_defines.vh"
`default_nettype none

module clock_source_select (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Oscillator sources, sampled as enables on mclk
    input wire onchip_clock,
    input wire main_clock,
    input wire sub_clock,
    // Core control
    input wire rc_oscillator_select_command,
    input wire system_clock_select_high,
    input wire system_clock_select_low,
    input wire division_mode_high,
    input wire division_mode_low,
    input wire clock_control_write,
    // Oscillator control
    output reg ceramic_enable,
    output reg rc_enable,
    output reg rc_selected,
    // Clocks out
    output reg system_clock,
    output reg instruction_clock,
    output reg [1:0] clock_select,
    output reg [1:0] division_mode
);

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    function [1:0] div_ratio;
        input [1:0] mode;
        begin
            case (mode)
                `DIV_THROUGH: div_ratio = 2'h0;
                `DIV_BY2: div_ratio = 2'h1;
                // Codes 10 and 11 both give divide-by-4
                default: div_ratio = 2'h3;
            endcase
        end
    endfunction

    // ----------------------------------------
    // RC latch
    // ----------------------------------------
    reg rc_flag_r;
    reg rc_flag_nxt;

    // Set-once; later commands change nothing
    always @* begin
        rc_flag_nxt = rc_flag_r;
        if (rc_oscillator_select_command) begin
            rc_flag_nxt = 1'b1;
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rc_flag_r <= 1'b0;
        end else begin
            rc_flag_r <= rc_flag_nxt;
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ceramic_enable <= 1'b1;
            rc_enable <= 1'b0;
            rc_selected <= 1'b0;
        end else begin
            ceramic_enable <= ~rc_flag_r;
            rc_enable <= rc_flag_r;
            rc_selected <= rc_flag_r;
        end
    end

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    // Reset leaves the on-chip clock divided by 4
    reg [1:0] select_nxt;
    reg [1:0] mode_nxt;

    always @* begin
        select_nxt = clock_select;
        mode_nxt = division_mode;
        if (clock_control_write) begin
            select_nxt = {system_clock_select_high, system_clock_select_low};
            mode_nxt = {division_mode_high, division_mode_low};
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clock_select <= `SEL_RESET;
            division_mode <= `DIV_RESET;
        end else begin
            clock_select <= select_nxt;
            division_mode <= mode_nxt;
        end
    end

    // ----------------------------------------
    // Source edge detectors
    // ----------------------------------------
    // Each source keeps its own history, so a change of select cannot
    // turn the new source's high level into a false tick.
    wire [2:0] src_level;
    wire [2:0] src_rise;

    assign src_level = {sub_clock, main_clock, onchip_clock};

    genvar gi;

    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
            reg level_r;

            always @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    level_r <= 1'b0;
                end else begin
                    level_r <= src_level[gi];
                end
            end

            assign src_rise[gi] = src_level[gi] & ~level_r;
        end
    endgenerate

    // ----------------------------------------
    // Multiplexer
    // ----------------------------------------
    reg src_edge;

    always @* begin
        case (clock_select)
            `SEL_ONCHIP: src_edge = src_rise[0];
            `SEL_MAIN: src_edge = src_rise[1];
            `SEL_SUB: src_edge = src_rise[2];
            default: src_edge = src_rise[0];
        endcase
    end

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    // Sources are treated as tick enables; glitch-free switching is traded
    // for a single-clock design.
    reg [1:0] div_cnt_r;
    reg [1:0] div_cnt_nxt;
    reg [1:0] div_limit;
    reg tick_nxt;

    always @* begin
        div_limit = div_ratio(division_mode);
    end

    always @* begin
        div_cnt_nxt = div_cnt_r;
        tick_nxt = 1'b0;
        if (src_edge) begin
            if (div_cnt_r >= div_limit) begin
                div_cnt_nxt = 2'h0;
                tick_nxt = 1'b1;
            end else begin
                div_cnt_nxt = div_cnt_r + 2'h1;
            end
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_r <= 2'h0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
        end
    end

    // ----------------------------------------
    // Clock outputs
    // ----------------------------------------
    // Instruction clock ticks every second system tick
    reg sys_toggle_r;
    reg sys_toggle_nxt;
    reg ins_tick_nxt;

    always @* begin
        sys_toggle_nxt = sys_toggle_r;
        ins_tick_nxt = 1'b0;
        if (tick_nxt) begin
            sys_toggle_nxt = ~sys_toggle_r;
            ins_tick_nxt = sys_toggle_r;
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sys_toggle_r <= 1'b0;
        end else begin
            sys_toggle_r <= sys_toggle_nxt;
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            system_clock <= 1'b0;
            instruction_clock <= 1'b0;
        end else begin
            system_clock <= tick_nxt;
            instruction_clock <= ins_tick_nxt;
        end
    end

endmodule
`default_nettype wire

/* File: clock_source_select_defines.vh */
`ifndef CLOCK_SOURCE_SELECT_DEFINES_VH
`define CLOCK_SOURCE_SELECT_DEFINES_VH

// ----------------------------------------
// System clock select codes
// ----------------------------------------
`define SEL_ONCHIP 2'h0
`define SEL_MAIN 2'h1
`define SEL_SUB 2'h2
`define SEL_RESET 2'h0

// ----------------------------------------
// Division mode codes
// ----------------------------------------
`define DIV_THROUGH 2'h0
`define DIV_BY2 2'h1
`define DIV_BY4_A 2'h2
`define DIV_BY4_B 2'h3
`define DIV_RESET 2'h3

`endif

/* File: clock_source_select_properties.sv */
`default_nettype none
module clock_source_select_properties (
    input wire logic mclk, rst_b, rc_oscillator_select_command, clock_control_write,
    input wire logic system_clock_select_high, system_clock_select_low,
    input wire logic division_mode_high, division_mode_low, system_clock,
    input wire logic ceramic_enable, rc_enable, rc_selected,
    input wire logic [1:0] clock_select, division_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_rc_switch_on: assert property (rc_oscillator_select_command |-> ##2
        rc_enable && !ceramic_enable) else $error("rc switch late");
    a_rc_one_way: assert property (rc_enable |=> rc_enable)
        else $error("rc mode dropped");
    a_rc_needs_cmd: assert property ($rose(rc_enable) |->
        $past(rc_oscillator_select_command, 2)) else $error("rc without command");
    a_osc_pair: assert property (ceramic_enable == !rc_enable && rc_selected == rc_enable)
        else $error("oscillator paths disagree");
    a_reset_state: assert property (disable iff (1'b0) !rst_b |=>
        ceramic_enable && !rc_enable && clock_select == 2'h0 && division_mode == 2'h3)
        else $error("bad reset state");
    a_field_load: assert property (clock_control_write |=>
        {clock_select, division_mode} == $past({system_clock_select_high,
        system_clock_select_low, division_mode_high, division_mode_low}))
        else $error("fields not loaded");
    a_field_hold: assert property (!clock_control_write |=> $stable(clock_select)
        && $stable(division_mode)) else $error("fields moved");
    a_sys_single: assert property (system_clock |=> !system_clock)
        else $error("system clock too wide");
    cover property (rc_enable);
    cover property (system_clock && division_mode == 2'h0);
    cover property (system_clock && clock_select == 2'h2);
endmodule
bind clock_source_select clock_source_select_properties chk_i (.*);
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst_b = 0, onchip_clock = 0, main_clock = 0, sub_clock = 0;
    logic rc_oscillator_select_command = 0, clock_control_write = 0;
    logic system_clock_select_high = 0, system_clock_select_low = 0;
    logic division_mode_high = 0, division_mode_low = 0;
    wire ceramic_enable, rc_enable, rc_selected, system_clock, instruction_clock;
    wire [1:0] clock_select, division_mode;
    int errors = 0, n_tests = 0, cyc = 0, n_sys = 0, n_ins = 0;
    clock_source_select dut (.*);
    always #20 mclk = ~mclk;
    // Timeout well above the roughly 470 cycles the run needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        n_sys <= n_sys + (system_clock === 1'b1);
        n_ins <= n_ins + (instruction_clock === 1'b1);
        if (cyc == 2000) begin
            errors++;
            close_out();
        end
    end
    task chk(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask
    task rst();
        rst_b = 0;
        repeat (6) @(negedge mclk);
        rst_b = 1;
    endtask
    task pulse_rc();
        rc_oscillator_select_command = 1;
        @(negedge mclk);
        rc_oscillator_select_command = 0;
        repeat (2) @(negedge mclk);
    endtask
    task rc_test();
        rst();
        chk("osc", {ceramic_enable, rc_enable, rc_selected, clock_select}, 5'h10);
        chk("division_mode", division_mode, 2'h3);
        pulse_rc();
        chk("osc", {ceramic_enable, rc_enable, rc_selected}, 3'h3);
        pulse_rc();
        chk("osc", {ceramic_enable, rc_enable, rc_selected}, 3'h3);
        rst();
        chk("osc", {ceramic_enable, rc_enable, rc_selected}, 3'h4);
    endtask
    // Source rises per run; fresh reset keeps the divider phase known
    task run(input logic [1:0] s, m, input logic [2:0] src, input int e);
        int b;
        int bi;
        rst();
        {system_clock_select_high, system_clock_select_low} = s;
        {division_mode_high, division_mode_low} = m;
        clock_control_write = 1;
        @(negedge mclk);
        clock_control_write = 0;
        @(negedge mclk);
        chk("fields", {clock_select, division_mode}, {s, m});
        b = n_sys;
        bi = n_ins;
        repeat (12) begin
            {onchip_clock, main_clock, sub_clock} = src;
            repeat (2) @(negedge mclk);
            {onchip_clock, main_clock, sub_clock} = 3'h0;
            repeat (2) @(negedge mclk);
        end
        chk("system_clock", n_sys - b, e);
        chk("instruction_clock", n_ins - bi, e / 2);
    endtask
    task close_out();
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        rc_test();
        run(2'h0, 2'h0, 3'h4, 12);
        run(2'h1, 2'h0, 3'h2, 12);
        run(2'h2, 2'h0, 3'h1, 12);
        run(2'h3, 2'h0, 3'h4, 12);
        run(2'h1, 2'h1, 3'h2, 6);
        run(2'h1, 2'h2, 3'h2, 3);
        run(2'h1, 2'h3, 3'h2, 3);
        run(2'h2, 2'h0, 3'h6, 0);
        close_out();
    end
endmodule
`default_nettype wire
